// >>> hdl/uvrb_pkg.sv
`default_nettype none

package uvrb_pkg;

   // ****************************************
   // register addresses of the result bank
   // ****************************************
   localparam logic [2:0] ADDR_STATE = 3'h0;
   localparam logic [2:0] ADDR_THERMAL = 3'h1;
   localparam logic [2:0] ADDR_CHAN_A = 3'h2;
   localparam logic [2:0] ADDR_CHAN_B = 3'h3;
   localparam logic [2:0] ADDR_CHAN_C = 3'h4;
   localparam logic [2:0] ADDR_TIME_LOW = 3'h5;
   localparam logic [2:0] ADDR_TIME_HIGH = 3'h6;

   // ****************************************
   // field layouts and reset values
   // ****************************************
   localparam int STAT_TIME_OVF = 7;
   localparam int STAT_RES_OVF = 6;
   localparam int STAT_CONV_OVF = 5;
   localparam int STAT_LOST = 4;
   localparam int STAT_FRESH = 3;
   localparam int STAT_MEASURING = 2;
   localparam int STAT_STANDBY = 1;
   localparam int STAT_POWERDOWN = 0;
   localparam int THERMAL_BITS = 12;
   localparam int CHAN_BITS = 16;
   localparam int TIME_BITS = 24;
   localparam logic [7:0] STATE_RESET = 8'h00;
   localparam logic [7:0] FILLER_BYTE = 8'h00;
   localparam logic [7:0] MISS_BYTE = 8'h00;
   localparam logic [15:0] CHAN_SATURATED = 16'hFFFF;
   localparam logic [3:0] TIME_SETTING_LONG = 4'h7;

   // ****************************************
   // carriers
   // ****************************************
   // raw counts from the converter core; the extra top bit of a channel is its carry
   typedef struct packed {
      logic [THERMAL_BITS-1:0] thermal;
      logic [CHAN_BITS:0] chanA;
      logic [CHAN_BITS:0] chanB;
      logic [CHAN_BITS:0] chanC;
      logic [TIME_BITS-1:0] convTime;
      logic timeWrapped;
      logic convOverdrive;
   } uvrb_raw_t;

   // one complete result set, buffered or published
   typedef struct packed {
      logic [15:0] thermal;
      logic [15:0] chanA;
      logic [15:0] chanB;
      logic [15:0] chanC;
      logic [TIME_BITS-1:0] convTime;
      logic timeOvf;
      logic resOvf;
      logic convOvf;
   } uvrb_res_t;

   // byte read request from the serial engine
   typedef struct packed {
      logic [2:0] addr;
      logic upper;
   } uvrb_rdreq_t;

endpackage

`default_nettype wire

// >>> hdl/uvrb_capture.sv
`timescale 1ns/1ns
`default_nettype none

module uvrb_capture (
   input wire logic clk_sys, // system clock
   input wire logic reset_n, // async reset, active low
   input wire logic clearBank, // clears the buffer
   input wire logic measLoad, // end of a measurement cycle
   input wire uvrb_pkg::uvrb_raw_t meas, // raw converter results
   input wire logic external_start_stop_mode, // externally synchronized mode
   input wire logic time_measure_enable, // time measurement enabled
   input wire logic [3:0] conversion_time_setting, // conversion time setting
   output uvrb_pkg::uvrb_res_t bufSet // buffered result set
);
   import uvrb_pkg::*;

   uvrb_res_t next_bufSet;

   function automatic logic [15:0] satChan(input logic [CHAN_BITS:0] raw);
      satChan = raw[CHAN_BITS] ? CHAN_SATURATED : raw[CHAN_BITS-1:0];
   endfunction

   // ****************************************
   // buffer load
   // ****************************************
   always_comb begin
      next_bufSet = bufSet;
      if (clearBank) begin
         next_bufSet = '0;
      end else if (measLoad) begin
         next_bufSet.thermal = {4'h0, meas.thermal};
         next_bufSet.chanA = satChan(meas.chanA);
         next_bufSet.chanB = satChan(meas.chanB);
         next_bufSet.chanC = satChan(meas.chanC);
         // the core counter restarts from zero after the wrap
         next_bufSet.convTime = meas.convTime;
         next_bufSet.timeOvf = meas.timeWrapped & external_start_stop_mode
            & time_measure_enable;
         // a carry cannot arise below the long time settings
         next_bufSet.resOvf = (meas.chanA[CHAN_BITS] | meas.chanB[CHAN_BITS]
            | meas.chanC[CHAN_BITS]) & (conversion_time_setting >= TIME_SETTING_LONG);
         next_bufSet.convOvf = meas.convOverdrive;
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         bufSet <= '0;
      end else begin
         bufSet <= next_bufSet;
      end
   end

endmodule

`default_nettype wire

// >>> hdl/uvrb_result_bank.sv
`timescale 1ns/1ns
`default_nettype none

module uvrb_result_bank (
   input wire logic clk_sys, // system clock, 25 MHz
   input wire logic reset_n, // async reset, active low
   input wire logic measState, // device is in measurement state
   input wire logic swReset, // software reset pulse
   input wire logic measLoad, // pulse: measurement cycle finished
   input wire uvrb_pkg::uvrb_raw_t meas, // raw results with measLoad
   input wire logic external_start_stop_mode, // externally synchronized mode
   input wire logic time_measure_enable, // time measurement enabled
   input wire logic [3:0] conversion_time_setting, // conversion time setting
   input wire logic measuring, // measurement in progress
   input wire logic standbyLive, // live internal standby signal
   input wire logic powerdownLive, // live internal powerdown signal
   input wire logic rdOpStart, // pulse: serial read operation begins
   input wire logic i2cStop, // pulse: stop condition seen
   input wire logic rdReq, // pulse: one byte wanted
   input wire uvrb_pkg::uvrb_rdreq_t rdSel, // address and byte half
   input wire logic wrReq, // pulse: one byte written
   input wire logic [2:0] wrAddr, // write index address
   input wire logic [7:0] wrData, // write byte
   output logic [7:0] rdData, // byte answer
   output logic rdAck, // pulse: rdData valid
   output logic rdMiss, // pulse: read refused, bank closed
   output logic [7:0] operating_state_ctrl, // state byte
   output logic [7:0] sensor_flags, // status byte, registered one cycle late
   output logic readyLevel, // ready pin level, high when idle
   output logic readActive // bank frozen by a read
);
   import uvrb_pkg::*;

   // ****************************************
   // declarations
   // ****************************************
   uvrb_res_t bufSet;
   uvrb_res_t resSet;
   uvrb_res_t next_resSet;
   logic bufNew;
   logic next_bufNew;
   logic lost_results_flag;
   logic next_lost_results_flag;
   logic fresh_results_flag;
   logic next_fresh_results_flag;
   logic next_readActive;
   logic measPrev;
   logic next_measPrev;
   logic clearBank;
   logic transfer;
   logic bankRead;
   logic statusRead;
   logic resultRead;
   logic [7:0] next_rdData;
   logic next_rdAck;
   logic next_rdMiss;
   logic [7:0] next_operating_state_ctrl;
   logic standby_live_flag;
   logic powerdown_live_flag;
   logic next_standby_live_flag;
   logic next_powerdown_live_flag;
   logic next_readyLevel;
   logic [7:0] statusByte;
   logic [7:0] next_sensor_flags;

   // ****************************************
   // byte picker
   // ****************************************
   // every location is 16 bits wide; the half bit picks the byte
   function automatic logic [7:0] halfOf(input logic [15:0] word, input logic upper);
      halfOf = upper ? word[15:8] : word[7:0];
   endfunction

   function automatic logic [7:0] pickByte(
      input uvrb_res_t res,
      input logic [7:0] stateByte,
      input logic [7:0] statByte,
      input uvrb_rdreq_t sel
   );
      case (sel.addr)
         ADDR_STATE: begin
            pickByte = halfOf({statByte, stateByte}, sel.upper);
         end
         ADDR_THERMAL: begin
            pickByte = halfOf(res.thermal, sel.upper);
         end
         ADDR_CHAN_A: begin
            pickByte = halfOf(res.chanA, sel.upper);
         end
         ADDR_CHAN_B: begin
            pickByte = halfOf(res.chanB, sel.upper);
         end
         ADDR_CHAN_C: begin
            pickByte = halfOf(res.chanC, sel.upper);
         end
         ADDR_TIME_LOW: begin
            pickByte = halfOf(res.convTime[15:0], sel.upper);
         end
         ADDR_TIME_HIGH: begin
            pickByte = halfOf({FILLER_BYTE, res.convTime[23:16]}, sel.upper);
         end
         default: begin
            pickByte = MISS_BYTE;
         end
      endcase
   endfunction

   // ****************************************
   // buffer stage
   // ****************************************
   uvrb_capture capture (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .clearBank(clearBank),
      .measLoad(measLoad),
      .meas(meas),
      .external_start_stop_mode(external_start_stop_mode),
      .time_measure_enable(time_measure_enable),
      .conversion_time_setting(conversion_time_setting),
      .bufSet(bufSet)
   );

   // ****************************************
   // decode of events
   // ****************************************
   // leaving the measurement state counts as a return to configuration
   assign clearBank = swReset | (measPrev & ~measState);
   // a repeated start inside an open read does not refresh the bank
   assign transfer = rdOpStart & measState & ~readActive & ~clearBank;
   assign bankRead = rdReq & measState;
   assign statusRead = bankRead & (rdSel.addr == ADDR_STATE) & rdSel.upper;
   assign resultRead = bankRead & (rdSel.addr >= ADDR_THERMAL) & (rdSel.addr <= ADDR_TIME_HIGH);

   always_comb begin
      statusByte = '0;
      statusByte[STAT_TIME_OVF] = resSet.timeOvf;
      statusByte[STAT_RES_OVF] = resSet.resOvf;
      statusByte[STAT_CONV_OVF] = resSet.convOvf;
      statusByte[STAT_LOST] = lost_results_flag;
      statusByte[STAT_FRESH] = fresh_results_flag;
      statusByte[STAT_MEASURING] = ~readyLevel;
      statusByte[STAT_STANDBY] = standby_live_flag;
      statusByte[STAT_POWERDOWN] = powerdown_live_flag;
   end

   // ****************************************
   // result registers and data flags
   // ****************************************
   always_comb begin
      next_resSet = resSet;
      next_bufNew = bufNew;
      next_lost_results_flag = lost_results_flag;
      next_fresh_results_flag = fresh_results_flag;
      next_readActive = readActive;
      if (clearBank) begin
         next_resSet = '0;
         next_bufNew = 1'b0;
         next_lost_results_flag = 1'b0;
         next_fresh_results_flag = 1'b0;
         next_readActive = 1'b0;
      end else begin
         if (transfer) begin
            next_resSet = bufSet;
            next_readActive = 1'b1;
         end else if (i2cStop) begin
            next_readActive = 1'b0;
         end
         // a load in the transfer cycle leaves the newer set waiting
         if (measLoad) begin
            next_bufNew = 1'b1;
         end else if (transfer) begin
            next_bufNew = 1'b0;
         end
         // clear first so that a coinciding set wins
         if (statusRead) begin
            next_lost_results_flag = 1'b0;
         end
         if (measLoad & bufNew & ~transfer) begin
            next_lost_results_flag = 1'b1;
         end
         if (statusRead | resultRead) begin
            next_fresh_results_flag = 1'b0;
         end
         if (transfer & bufNew) begin
            next_fresh_results_flag = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         resSet <= '0;
         bufNew <= 1'b0;
         lost_results_flag <= 1'b0;
         fresh_results_flag <= 1'b0;
         readActive <= 1'b0;
      end else begin
         resSet <= next_resSet;
         bufNew <= next_bufNew;
         lost_results_flag <= next_lost_results_flag;
         fresh_results_flag <= next_fresh_results_flag;
         readActive <= next_readActive;
      end
   end

   // ****************************************
   // live control bits
   // ****************************************
   // registered once so that the status byte and ready pin move together
   always_comb begin
      next_standby_live_flag = standbyLive;
      next_powerdown_live_flag = powerdownLive;
      next_readyLevel = ~measuring;
      next_measPrev = measState;
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         standby_live_flag <= 1'b0;
         powerdown_live_flag <= 1'b0;
         readyLevel <= 1'b1;
         measPrev <= 1'b0;
      end else begin
         standby_live_flag <= next_standby_live_flag;
         powerdown_live_flag <= next_powerdown_live_flag;
         readyLevel <= next_readyLevel;
         measPrev <= next_measPrev;
      end
   end

   // ****************************************
   // read answer
   // ****************************************
   // the answer is built from the registers before this cycle's transfer,
   // so the engine must leave a cycle between rdOpStart and the first rdReq
   always_comb begin
      next_rdData = MISS_BYTE;
      next_rdAck = 1'b0;
      next_rdMiss = 1'b0;
      if (rdReq) begin
         if (measState) begin
            next_rdData = pickByte(resSet, operating_state_ctrl, statusByte, rdSel);
            next_rdAck = 1'b1;
         end else begin
            next_rdMiss = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         rdData <= MISS_BYTE;
         rdAck <= 1'b0;
         rdMiss <= 1'b0;
      end else begin
         rdData <= next_rdData;
         rdAck <= next_rdAck;
         rdMiss <= next_rdMiss;
      end
   end

   // ****************************************
   // state byte and status mirror
   // ****************************************
   // the state byte survives a return to configuration, since that
   // return is itself written here; only a software reset clears it
   always_comb begin
      next_operating_state_ctrl = operating_state_ctrl;
      if (swReset) begin
         next_operating_state_ctrl = STATE_RESET;
      end else if (wrReq & (wrAddr == ADDR_STATE)) begin
         next_operating_state_ctrl = wrData;
      end
      next_sensor_flags = statusByte;
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         operating_state_ctrl <= STATE_RESET;
         sensor_flags <= '0;
      end else begin
         operating_state_ctrl <= next_operating_state_ctrl;
         sensor_flags <= next_sensor_flags;
      end
   end

endmodule

`default_nettype wire

// >>> sim/uvrb_result_bank_chk.sv
`timescale 1ns/1ns
`default_nettype none

module uvrb_result_bank_chk (
   input wire logic clk_sys, // clock
   input wire logic reset_n, // reset, low
   input wire logic measState, // bank open
   input wire logic swReset, // soft reset
   input wire logic measLoad, // new set
   input wire logic measuring, // busy
   input wire logic standbyLive, // live standby
   input wire logic powerdownLive, // live powerdown
   input wire logic rdOpStart, // read start
   input wire logic i2cStop, // stop
   input wire logic rdReq, // byte request
   input wire uvrb_pkg::uvrb_rdreq_t rdSel, // byte select
   input wire logic wrReq, // byte write
   input wire logic [2:0] wrAddr, // write address
   input wire logic [7:0] wrData, // write byte
   input wire logic [7:0] rdData, // answer
   input wire logic rdAck, // answer valid
   input wire logic rdMiss, // refused
   input wire logic [7:0] operating_state_ctrl, // state byte
   input wire logic [7:0] sensor_flags, // status copy
   input wire logic readyLevel, // ready pin
   input wire logic readActive // frozen
);
   import uvrb_pkg::*;
   default clocking @(posedge clk_sys);
   endclocking
   default disable iff (!reset_n);
   // *****
   // sequences
   // *****
   sequence open_rd;
      rdReq && measState;
   endsequence
   // a transfer in the same cycle may set fresh again, so it is left out
   sequence result_rd;
      open_rd ##0 (rdSel.addr inside {[ADDR_THERMAL:ADDR_TIME_HIGH]}) && !rdOpStart;
   endsequence
   sequence status_rd;
      open_rd ##0 rdSel.addr == ADDR_STATE && rdSel.upper && !measLoad;
   endsequence
   // *****
   // assertions
   // *****
   read_ack_a: assert property (open_rd |=> rdAck && !rdMiss)
      else $error("open bank read not acknowledged");
   read_miss_a: assert property (rdReq && !measState |=> rdMiss && !rdAck && rdData == 8'h00)
      else $error("closed bank read not refused");
   state_write_a: assert property (wrReq && wrAddr == ADDR_STATE && !swReset
      |=> operating_state_ctrl == $past(wrData)) else $error("state byte write lost");
   state_hold_a: assert property (!(wrReq && wrAddr == ADDR_STATE) && !swReset
      |=> $stable(operating_state_ctrl)) else $error("state byte changed unasked");
   ready_low_a: assert property (measuring |=> !readyLevel ##1 sensor_flags[STAT_MEASURING])
      else $error("busy not shown");
   ready_high_a: assert property (!measuring |=> readyLevel ##1 !sensor_flags[STAT_MEASURING])
      else $error("idle not shown");
   live_bits_a: assert property (!swReset |-> ##2
      sensor_flags[STAT_STANDBY] == $past(standbyLive, 2)
      && sensor_flags[STAT_POWERDOWN] == $past(powerdownLive, 2)) else $error("live bits wrong");
   // outside the measurement state a read start opens nothing
   freeze_on_a: assert property (rdOpStart && measState && !swReset |=> readActive)
      else $error("bank not frozen by read");
   freeze_off_a: assert property (i2cStop && !rdOpStart |=> !readActive)
      else $error("bank still frozen after stop");
   fresh_clear_a: assert property (result_rd |-> ##2 !sensor_flags[STAT_FRESH])
      else $error("fresh flag kept after result read");
   lost_clear_a: assert property (status_rd |-> ##2 !sensor_flags[STAT_LOST])
      else $error("lost flag kept after status read");
endmodule

bind uvrb_result_bank uvrb_result_bank_chk chk (
   .clk_sys, .reset_n, .measState, .swReset, .measLoad, .measuring, .standbyLive,
   .powerdownLive, .rdOpStart, .i2cStop, .rdReq, .rdSel, .wrReq, .wrAddr, .wrData,
   .rdData, .rdAck, .rdMiss, .operating_state_ctrl, .sensor_flags, .readyLevel,
   .readActive
);
`default_nettype wire

// >>> sim/uvrb_host_model.sv
`timescale 1ns/1ns
`default_nettype none

module uvrb_host_model (
   input wire logic clk_sys, // clock
   input wire logic [7:0] rdData, // answer byte
   input wire logic rdAck, // byte valid
   input wire logic rdMiss, // byte refused
   output var logic rdOpStart, // read start
   output var logic i2cStop, // stop
   output var logic rdReq, // byte request
   output var uvrb_pkg::uvrb_rdreq_t rdSel, // byte select
   output var logic wrReq, // byte write
   output var logic [2:0] wrAddr, // write address
   output var logic [7:0] wrData // write byte
);
   import uvrb_pkg::*;
   logic [7:0] got[16];
   logic [1:0] ans[16];
   initial begin
      {rdOpStart, i2cStop, rdReq, wrReq} = 4'h0;
      rdSel = '0;
      wrAddr = 3'h0;
      wrData = 8'h00;
   end
   // *****
   // transfers
   // *****
   // start or repeated start of a read operation
   task automatic start_op();
      @(posedge clk_sys) rdOpStart <= 1'b1;
      @(posedge clk_sys) rdOpStart <= 1'b0;
   endtask
   // bytes are requested back to back; gap idles before the first byte and the stop
   task automatic rd(input logic [2:0] a0, input int n, input int gap);
      int m;
      m = 2 * n;
      start_op();
      repeat (gap) @(posedge clk_sys);
      for (int i = 0; i <= m; i++) begin
         rdReq <= i < m;
         rdSel <= '{addr: a0 + 3'(i / 2), upper: i[0]};
         if (i > 0) begin
            #1;
            got[i - 1] = rdData;
            ans[i - 1] = {rdAck, rdMiss};
         end
         @(posedge clk_sys);
      end
      repeat (gap) @(posedge clk_sys);
      i2cStop <= 1'b1;
      @(posedge clk_sys) i2cStop <= 1'b0;
   endtask
   function automatic logic [15:0] word(input int k);
      return {got[2 * k + 1], got[2 * k]};
   endfunction
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk_sys) begin
         wrReq <= 1'b1;
         wrAddr <= a;
         wrData <= d;
      end
      @(posedge clk_sys) begin
         wrReq <= 1'b0;
         wrData <= ~d;
      end
   endtask
endmodule
`default_nettype wire

// >>> sim/uvrb_result_bank_tb_top.sv
`timescale 1ns/1ns
`default_nettype none

module uvrb_result_bank_tb_top;
   import uvrb_pkg::*;
   logic clk_sys = 1'b0;
   logic reset_n = 1'b0;
   logic measState = 1'b0;
   logic swReset = 1'b0;
   logic measLoad = 1'b0;
   uvrb_raw_t meas = '0;
   logic syncMode = 1'b0;
   logic timeEn = 1'b0;
   logic [3:0] timeSet = 4'h0;
   logic measuring = 1'b0;
   logic standbyLive = 1'b0;
   logic powerdownLive = 1'b0;
   logic rdOpStart, i2cStop, rdReq, wrReq, rdAck, rdMiss, readyLevel, readActive;
   uvrb_rdreq_t rdSel;
   logic [2:0] wrAddr;
   logic [7:0] wrData, rdData, stateByte, flags;
   int numErrors = 0;
   int checksDone = 0;
   logic [15:0] fullWords[8] = '{16'hEAA5, 16'h0ABC, 16'h1234, 16'hFFFF, 16'hBEEF,
      16'h3456, 16'h0012, 16'h0000};

   always #20 clk_sys = ~clk_sys;

   uvrb_result_bank dut (
      .clk_sys, .reset_n, .measState, .swReset, .measLoad, .meas,
      .external_start_stop_mode(syncMode), .time_measure_enable(timeEn),
      .conversion_time_setting(timeSet), .measuring, .standbyLive, .powerdownLive,
      .rdOpStart, .i2cStop, .rdReq, .rdSel, .wrReq, .wrAddr, .wrData, .rdData, .rdAck,
      .rdMiss, .operating_state_ctrl(stateByte), .sensor_flags(flags), .readyLevel,
      .readActive
   );
   uvrb_host_model host (
      .clk_sys, .rdData, .rdAck, .rdMiss, .rdOpStart, .i2cStop, .rdReq, .rdSel, .wrReq,
      .wrAddr, .wrData
   );
   // *****
   // helpers
   // *****
   task automatic cmp(input string nm, input logic [15:0] exp, input logic [15:0] got);
      checksDone++;
      if (got !== exp) begin
         numErrors++;
         $display("ERROR %s expected %h got %h", nm, exp, got);
      end
   endtask
   task automatic report_and_stop();
      if (numErrors == 0 && checksDone > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // the converter data is scrambled after the pulse, so a late capture shows up
   task automatic load(input uvrb_raw_t r);
      @(posedge clk_sys) begin
         meas <= r;
         measLoad <= 1'b1;
      end
      @(posedge clk_sys) begin
         meas <= ~r;
         measLoad <= 1'b0;
      end
   endtask
   function automatic uvrb_raw_t raw(input logic [16:0] a);
      raw = '0;
      raw.chanA = a;
      raw.timeWrapped = 1'b1;
   endfunction
   // *****
   // scenarios
   // *****
   task automatic t_write();
      cmp("reset state", 16'(STATE_RESET), 16'(stateByte));
      cmp("reset flags", 16'h0000, 16'(flags));
      host.wr(ADDR_STATE, 8'hA5);
      #1 cmp("state write", 16'h00A5, 16'(stateByte));
      host.wr(ADDR_CHAN_B, 8'h5A);
      #1 cmp("other write", 16'h00A5, 16'(stateByte));
   endtask
   task automatic t_closed();
      host.rd(ADDR_CHAN_A, 1, 0);
      cmp("closed answer", 16'h0001, 16'(host.ans[0]));
      cmp("closed byte", 16'h0000, 16'(host.got[0]));
   endtask
   task automatic t_full();
      @(posedge clk_sys) begin
         measState <= 1'b1;
         syncMode <= 1'b1;
         timeEn <= 1'b1;
         timeSet <= TIME_SETTING_LONG;
         standbyLive <= 1'b1;
      end
      load('{thermal: 12'hABC, chanA: 17'h01234, chanB: 17'h1ABCD, chanC: 17'h0BEEF,
         convTime: 24'h123456, timeWrapped: 1'b1, convOverdrive: 1'b1});
      host.rd(ADDR_STATE, 8, 0);
      for (int k = 0; k < 8; k++) begin
         cmp("word", fullWords[k], host.word(k));
      end
      cmp("open answer", 16'h0002, 16'(host.ans[0]));
      repeat (3) @(posedge clk_sys);
      #1 cmp("flags after read", 16'h00E2, 16'(flags));
   endtask
   task automatic t_lost();
      @(posedge clk_sys) begin
         syncMode <= 1'b0;
         timeSet <= 4'h0;
         standbyLive <= 1'b0;
         powerdownLive <= 1'b1;
      end
      load(raw(17'h00F0F));
      load(raw(17'h01111));
      repeat (3) @(posedge clk_sys);
      #1 cmp("lost set", 16'h0001, 16'(flags[STAT_LOST]));
      // a repeated start while the read is open must not publish the newer set
      fork
         host.rd(ADDR_CHAN_A, 1, 6);
         begin
            repeat (3) @(posedge clk_sys);
            load(raw(17'h02222));
            host.start_op();
            #1 cmp("bank frozen", 16'h0001, 16'(readActive));
         end
      join
      cmp("frozen result", 16'h1111, host.word(0));
      @(posedge clk_sys);
      #1 cmp("lost kept", 16'h0001, 16'(flags[STAT_LOST]));
      host.rd(ADDR_CHAN_A, 1, 0);
      cmp("next transfer", 16'h2222, host.word(0));
      host.rd(ADDR_STATE, 1, 0);
      cmp("status word", 16'h11A5, host.word(0));
      repeat (2) @(posedge clk_sys);
      #1 cmp("lost cleared", 16'h0000, 16'(flags[STAT_LOST]));
   endtask
   task automatic t_clear();
      @(posedge clk_sys) begin
         measState <= 1'b0;
         measuring <= 1'b1;
      end
      repeat (2) @(posedge clk_sys);
      measState <= 1'b1;
      repeat (2) @(posedge clk_sys);
      #1 cmp("ready low", 16'h0000, 16'(readyLevel));
      cmp("busy flag", 16'h0001, 16'(flags[STAT_MEASURING]));
      host.rd(ADDR_CHAN_A, 1, 0);
      cmp("cleared result", 16'h0000, host.word(0));
      @(posedge clk_sys) swReset <= 1'b1;
      @(posedge clk_sys) swReset <= 1'b0;
      #1 cmp("state cleared", 16'(STATE_RESET), 16'(stateByte));
   endtask

   initial begin
      repeat (12) @(posedge clk_sys);
      reset_n <= 1'b1;
      @(posedge clk_sys);
      #1 t_write();
      t_closed();
      t_full();
      t_lost();
      t_clear();
      report_and_stop();
   end
   // the whole sequence needs about a hundred cycles
   initial begin
      repeat (5000) @(posedge clk_sys);
      numErrors++;
      report_and_stop();
   end
endmodule
`default_nettype wire
